// >>> shared/serial_iface_params.svh
`ifndef SERIAL_IFACE_PARAMS_SVH
`define SERIAL_IFACE_PARAMS_SVH

// Register offsets on the plain register port.
`define SI_ADDR_CTRL 2'h0
`define SI_ADDR_STATUS 2'h1
`define SI_ADDR_DATA 2'h2
`define SI_ADDR_BUFFER 2'h3

// Control register field positions.
`define SI_CTRL_SIE 7
`define SI_CTRL_OIE 6
`define SI_CTRL_WM_HI 5
`define SI_CTRL_WM_LO 4
`define SI_CTRL_CS_HI 3
`define SI_CTRL_CS_LO 2
`define SI_CTRL_CLK 1
`define SI_CTRL_TC 0

// Status register field positions.
`define SI_STAT_SIF 7
`define SI_STAT_OIF 6
`define SI_STAT_PF 5
`define SI_STAT_DC 4
`define SI_STAT_CNT_HI 3

// Reset values and counter constants.
`define SI_CTRL_RST 6'h00
`define SI_DATA_RST 8'h00
`define SI_CNT_RST 4'h0
`define SI_CNT_MAX 4'hf
`define SI_CNT_STEP 4'h1
`define SI_READ_IDLE 8'h00
`define SI_STROBE_READ 2'h0

`endif

// >>> shared/serial_iface_pkg.sv
package serial_iface_pkg;

    // Wire mode field encodings.
    typedef enum logic [1:0] {
        WIRE_OFF = 2'b00,
        WIRE_THREE = 2'b01,
        WIRE_TWO = 2'b10,
        WIRE_TWO_HOLD = 2'b11
    } wire_mode_e;

    // Clock source field encodings.
    typedef enum logic [1:0] {
        CLK_SOFT = 2'b00,
        CLK_TIMER = 2'b01,
        CLK_EXT_POS = 2'b10,
        CLK_EXT_NEG = 2'b11
    } clk_src_e;

endpackage : serial_iface_pkg

// >>> src/serial_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module serial_edge_detect (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level,
    output logic prevLevel,
    output logic rise,
    output logic fall
);

    logic prev_q;
    logic prev_d;

    // Idle lines float high, so reset to one avoids a false fall.
    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
        end
    end

    // Edges compare the present level with last cycle's.
    assign prevLevel = prev_q;
    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;

endmodule : serial_edge_detect

`default_nettype wire

// >>> src/serial_iface_wire_clock_select.sv
// Contract
// - Wire mode zero: pins act as port
// - Wire mode affects outputs only, inputs always
// - Three-wire: shift output replaces port bit
// - Three-wire: data-in and clock pins unchanged
// - Two-wire: open-drain, enabled by direction bits
// - Data line low if shift or port zero
// - Clock line low if port zero or hold
// - Start condition holds clock until flag cleared
// - Mode 11 also holds on counter overflow
// - Two-wire disables normal port function
// - Clock source select; external latch opposite edge
// - Internal clocking: output latch transparent
// - Source zero: strobe clocks register and counter
// - External source: strobe bit selects counter clock
// - Source 01: timer compare matches clock both
// - External edge polarity; counter on both edges
// - Strobe bit set: toggle strobe clocks counter
// - Overflow flag on wrap, cleared by one
// - Strobe bits read back as zero
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "serial_iface_params.svh"

module serial_iface_wire_clock_select (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic timerMatchA,
    input wire logic timerMatch,
    input wire logic portOutDo,
    input wire logic portOutSda,
    input wire logic portOutScl,
    input wire logic dirDo,
    input wire logic dirSda,
    input wire logic dirScl,
    input wire logic sdaPinIn,
    input wire logic sclPinIn,
    output logic doPinOut,
    output logic doPinOe,
    output logic doPullUp,
    output logic sdaPinOut,
    output logic sdaPinOe,
    output logic sdaPullUp,
    output logic sclPinOut,
    output logic sclPinOe,
    output logic sclPullUp,
    output logic toggleClkPort
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True for both two-wire encodings.
    function automatic logic isTwoWire(input serial_iface_pkg::wire_mode_e wm);
        isTwoWire = (wm == serial_iface_pkg::WIRE_TWO) ||
                    (wm == serial_iface_pkg::WIRE_TWO_HOLD);
    endfunction : isTwoWire

    ////////////////////////////////////////////////////////////////////////
    // State.

    logic [5:0] ctrl_q, ctrl_d;
    logic clkSel_q, clkSel_d;
    logic [7:0] data_q, data_d;
    logic [7:0] buffer_q, buffer_d;
    logic [3:0] count_q, count_d;
    logic startFlag_q, startFlag_d;
    logic ovfFlag_q, ovfFlag_d;
    logic stopFlag_q, stopFlag_d;
    logic outLatch_q, outLatch_d;
    logic toggle_q, toggle_d;
    logic [7:0] rdData_q, rdData_d;
    logic doOut_q, doOut_d;
    logic doOe_q, doOe_d;
    logic doPull_q, doPull_d;
    logic sdaOut_q, sdaOut_d;
    logic sdaOe_q, sdaOe_d;
    logic sdaPull_q, sdaPull_d;
    logic sclOut_q, sclOut_d;
    logic sclOe_q, sclOe_d;
    logic sclPull_q, sclPull_d;

    logic sdaPrev, sdaRise, sdaFall, sclRise, sclFall;
    logic ctrlWr, statWr, dataWr, strobeClk, strobeTc;
    logic shiftTick, countTick, overflow, startEvt, stopEvt;
    logic latchOpen, clockHold, collision;
    serial_iface_pkg::wire_mode_e wireNow;
    serial_iface_pkg::clk_src_e clkSrc;

    ////////////////////////////////////////////////////////////////////////
    // Input edge detection runs in every mode.

    // Inputs keep their function whatever the wire mode says.
    serial_edge_detect sdaEdge (
        .clock(clock),
        .nrst(nrst),
        .level(sdaPinIn),
        .prevLevel(sdaPrev),
        .rise(sdaRise),
        .fall(sdaFall)
    );

    serial_edge_detect sclEdge (
        .clock(clock),
        .nrst(nrst),
        .level(sclPinIn),
        .prevLevel(),
        .rise(sclRise),
        .fall(sclFall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Core next-state logic: control, shifter, counter and flags.

    // A clock source or select write takes effect in its own cycle (wire mode a cycle later), so a strobe written
    // together with a new clock source already uses that source.
    always_comb begin
        ctrlWr = regWr && (regAddr == `SI_ADDR_CTRL);
        statWr = regWr && (regAddr == `SI_ADDR_STATUS);
        dataWr = regWr && (regAddr == `SI_ADDR_DATA);
        ctrl_d = ctrlWr ? regWrData[7:2] : ctrl_q;
        clkSel_d = ctrlWr ? regWrData[`SI_CTRL_CLK] : clkSel_q;
        clkSrc = serial_iface_pkg::clk_src_e'(ctrl_d[1:0]);
        // A strobe exists only in its write cycle, one pulse per write.
        strobeClk = ctrlWr && regWrData[`SI_CTRL_CLK];
        strobeTc = ctrlWr && regWrData[`SI_CTRL_TC];
        shiftTick = 1'b0;
        countTick = 1'b0;
        case (clkSrc)
            serial_iface_pkg::CLK_SOFT: begin
                shiftTick = strobeClk;
                countTick = strobeClk;
            end
            serial_iface_pkg::CLK_TIMER: begin
                shiftTick = timerMatchA;
                countTick = timerMatch;
            end
            serial_iface_pkg::CLK_EXT_POS: begin
                shiftTick = sclRise;
                // The strobe bit now selects, it no longer strobes.
                countTick = clkSel_d ? strobeTc : (sclRise | sclFall);
            end
            serial_iface_pkg::CLK_EXT_NEG: begin
                shiftTick = sclFall;
                countTick = clkSel_d ? strobeTc : (sclRise | sclFall);
            end
            default: begin
                shiftTick = 1'b0;
                countTick = 1'b0;
            end
        endcase
        // A software write beats a shift in the same cycle; the bit
        // shifted in is the data level seen one cycle earlier.
        if (dataWr) begin
            data_d = regWrData;
        end else if (shiftTick) begin
            data_d = {data_q[6:0], sdaPrev};
        end else begin
            data_d = data_q;
        end
        overflow = countTick && !statWr && (count_q == `SI_CNT_MAX);
        if (statWr) begin
            count_d = regWrData[`SI_STAT_CNT_HI:0];
        end else if (countTick) begin
            count_d = count_q + `SI_CNT_STEP;
        end else begin
            count_d = count_q;
        end
        // A status write blocks the set, so a clear written in that cycle wins.
        ovfFlag_d = overflow ||
                    (ovfFlag_q && !(statWr && regWrData[`SI_STAT_OIF]));
        buffer_d = overflow ? data_d : buffer_q;
        // Start detector is off with outputs disabled.
        wireNow = serial_iface_pkg::wire_mode_e'(ctrl_q[3:2]);
        if (isTwoWire(wireNow)) begin
            startEvt = sdaFall && sclPinIn;
            stopEvt = sdaRise && sclPinIn;
        end else if (wireNow == serial_iface_pkg::WIRE_THREE) begin
            startEvt = sclRise || sclFall;
            stopEvt = 1'b0;
        end else begin
            startEvt = 1'b0;
            stopEvt = 1'b0;
        end
        startFlag_d = startEvt ||
                      (startFlag_q && !(statWr && regWrData[`SI_STAT_SIF]));
        stopFlag_d = stopEvt ||
                     (stopFlag_q && !(statWr && regWrData[`SI_STAT_PF]));
        // Internal sources keep the latch open; external sources open it
        // only in the half period before the sampling edge.
        if (clkSrc[1] == 1'b0) begin
            latchOpen = 1'b1;
        end else begin
            latchOpen = sclPinIn ^ ~clkSrc[0];
        end
        outLatch_d = latchOpen ? data_d[7] : outLatch_q;
        // Port logic flips the clock pin's port bit on this pulse.
        toggle_d = strobeTc;
    end

    // Core state registers.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `SI_CTRL_RST;
            clkSel_q <= 1'b0;
            data_q <= `SI_DATA_RST;
            buffer_q <= `SI_DATA_RST;
            count_q <= `SI_CNT_RST;
            startFlag_q <= 1'b0;
            ovfFlag_q <= 1'b0;
            stopFlag_q <= 1'b0;
            outLatch_q <= 1'b0;
            toggle_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            clkSel_q <= clkSel_d;
            data_q <= data_d;
            buffer_q <= buffer_d;
            count_q <= count_d;
            startFlag_q <= startFlag_d;
            ovfFlag_q <= ovfFlag_d;
            stopFlag_q <= stopFlag_d;
            outLatch_q <= outLatch_d;
            toggle_q <= toggle_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive logic.

    // Pins are registered, so they trail the state by one cycle; this
    // costs one system clock of latency but keeps outputs glitch free.
    always_comb begin
        clockHold = (isTwoWire(wireNow) && startFlag_q) ||
                    ((wireNow == serial_iface_pkg::WIRE_TWO_HOLD) &&
                     ovfFlag_q);
        doOut_d = portOutDo;
        doOe_d = dirDo;
        doPull_d = ~dirDo & portOutDo;
        sdaOut_d = portOutSda;
        sdaOe_d = dirSda;
        sdaPull_d = ~dirSda & portOutSda;
        sclOut_d = portOutScl;
        sclOe_d = dirScl;
        sclPull_d = ~dirScl & portOutScl;
        case (wireNow)
            serial_iface_pkg::WIRE_OFF: begin
                doOut_d = portOutDo;
            end
            serial_iface_pkg::WIRE_THREE: begin
                // Direction and pull-up stay with the port bits.
                doOut_d = outLatch_q;
                sdaOut_d = portOutSda;
                sclOut_d = portOutScl;
            end
            serial_iface_pkg::WIRE_TWO,
            serial_iface_pkg::WIRE_TWO_HOLD: begin
                // Open drain: only ever drive low, never high.
                sdaOut_d = 1'b0;
                sdaOe_d = dirSda & (~outLatch_q | ~portOutSda);
                sdaPull_d = 1'b0;
                sclOut_d = 1'b0;
                sclOe_d = dirScl & (~portOutScl | clockHold);
                sclPull_d = 1'b0;
            end
            default: begin
                doOut_d = portOutDo;
            end
        endcase
    end

    // Pin registers.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            doOut_q <= 1'b0;
            doOe_q <= 1'b0;
            doPull_q <= 1'b0;
            sdaOut_q <= 1'b0;
            sdaOe_q <= 1'b0;
            sdaPull_q <= 1'b0;
            sclOut_q <= 1'b0;
            sclOe_q <= 1'b0;
            sclPull_q <= 1'b0;
        end else begin
            doOut_q <= doOut_d;
            doOe_q <= doOe_d;
            doPull_q <= doPull_d;
            sdaOut_q <= sdaOut_d;
            sdaOe_q <= sdaOe_d;
            sdaPull_q <= sdaPull_d;
            sclOut_q <= sclOut_d;
            sclOe_q <= sclOe_d;
            sclPull_q <= sclPull_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port.

    // Read data stand only in the cycle after the strobe, else zero.
    always_comb begin
        collision = isTwoWire(wireNow) && (data_q[7] != sdaPinIn);
        rdData_d = `SI_READ_IDLE;
        if (regRd) begin
            case (regAddr)
                `SI_ADDR_CTRL: begin
                    rdData_d = {ctrl_q, `SI_STROBE_READ};
                end
                `SI_ADDR_STATUS: begin
                    rdData_d = {startFlag_q, ovfFlag_q, stopFlag_q,
                                collision, count_q};
                end
                `SI_ADDR_DATA: begin
                    rdData_d = data_q;
                end
                `SI_ADDR_BUFFER: begin
                    rdData_d = buffer_q;
                end
                default: begin
                    rdData_d = `SI_READ_IDLE;
                end
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= `SI_READ_IDLE;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign regRdData = rdData_q;
    assign toggleClkPort = toggle_q;
    assign doPinOut = doOut_q;
    assign doPinOe = doOe_q;
    assign doPullUp = doPull_q;
    assign sdaPinOut = sdaOut_q;
    assign sdaPinOe = sdaOe_q;
    assign sdaPullUp = sdaPull_q;
    assign sclPinOut = sclOut_q;
    assign sclPinOe = sclOe_q;
    assign sclPullUp = sclPull_q;

endmodule : serial_iface_wire_clock_select

`default_nettype wire

// >>> verif/serial_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module serial_far_end (
    input wire logic clock,
    input wire logic sdaPinOe,
    input wire logic sdaPinOut,
    input wire logic sclPinOe,
    input wire logic sclPinOut,
    output logic sdaPinIn,
    output logic sclPinIn
);
    logic sdaLow = 1'b0;
    logic sclLow = 1'b0;

    // Both lines carry pull-ups, so a line nobody pulls low reads high.
    assign sdaPinIn = !((sdaPinOe && !sdaPinOut) || sdaLow);
    assign sclPinIn = !((sclPinOe && !sclPinOut) || sclLow);

    ////////////////////////////////////////////////////////////////
    // One slow clock pulse, low then high, so each level spans several system cycles.
    task automatic clk_pulse();
        @(posedge clock);
        sclLow <= 1'b1;
        repeat (3) @(posedge clock);
        sclLow <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : clk_pulse

    // Pulls or releases the data line and waits for the edge to be seen.
    task automatic set_sda(input logic low);
        @(posedge clock);
        sdaLow <= low;
        repeat (3) @(posedge clock);
    endtask : set_sda
endmodule : serial_far_end

`default_nettype wire

// >>> verif/serial_iface_chk.sv
`timescale 1ns/1ps
`default_nettype none

module serial_iface_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic dirDo,
    input wire logic dirScl,
    input wire logic portOutScl,
    input wire logic sdaPinIn,
    input wire logic sclPinIn,
    input wire logic doPinOe,
    input wire logic sclPinOe,
    input wire logic sclPinOut,
    input wire logic sclPullUp,
    input wire logic toggleClkPort
);
    logic [1:0] modeQ;
    logic [1:0] modeD;
    logic ctlWr;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Shadow of the wire mode; pin rules are judged only while it is steady.
    assign ctlWr = regWr && regAddr == 2'h0;
    always_comb begin
        modeD = ctlWr ? regWrData[5:4] : modeQ;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            modeQ <= 2'h0;
        end else begin
            modeQ <= modeD;
        end
    end

    ////////////////////////////////////////////////////////////////
    strobe_read_zero_a: assert property (
        regRd && regAddr == 2'h0 |=> regRdData[1:0] == 2'h0)
        else $error("Strobe bits read back as one");
    toggle_pulse_a: assert property (
        ctlWr && regWrData[0] |=> toggleClkPort)
        else $error("Toggle write gave no pulse");
    toggle_cause_a: assert property (
        toggleClkPort |-> $past(ctlWr) && $past(regWrData[0]))
        else $error("Toggle pulse without a toggle write");
    port_mode_a: assert property (
        !ctlWr && modeQ == 2'h0 |=> sclPinOe == $past(dirScl) && sclPinOut == $past(portOutScl))
        else $error("Clock pin not plain port in mode zero");
    three_wire_a: assert property (
        !ctlWr && modeQ == 2'h1 |=> doPinOe == $past(dirDo) && sclPinOe == $past(dirScl))
        else $error("Three-wire pin enables wrong");
    two_wire_pull_a: assert property (
        !ctlWr && modeQ[1] |=> !sclPullUp && !sclPinOut)
        else $error("Clock pin not open-drain in two-wire mode");
    scl_release_a: assert property (
        !ctlWr && modeQ[1] && !dirScl |=> !sclPinOe)
        else $error("Clock driver on without direction bit");
    scl_low_a: assert property (
        !ctlWr && modeQ[1] && dirScl && !portOutScl |=> sclPinOe)
        else $error("Clock line not pulled low by port bit");
    start_hold_a: assert property (
        !ctlWr && modeQ[1] && dirScl && sclPinIn && $fell(sdaPinIn) |-> ##[1:4] sclPinOe)
        else $error("Start condition did not hold the clock");

    cover property (ctlWr && regWrData[0]);
    cover property (modeQ == 2'h3 && sclPinOe);
    cover property (modeQ[1] && sclPinIn && $fell(sdaPinIn));
endmodule : serial_iface_chk

bind serial_iface_wire_clock_select serial_iface_chk i_chk (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dirDo(dirDo),
    .dirScl(dirScl), .portOutScl(portOutScl), .sdaPinIn(sdaPinIn),
    .sclPinIn(sclPinIn), .doPinOe(doPinOe), .sclPinOe(sclPinOe),
    .sclPinOut(sclPinOut), .sclPullUp(sclPullUp), .toggleClkPort(toggleClkPort)
);

`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, timerMatchA = 1'b0, timerMatch = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic portOutDo = 1'b1, portOutSda = 1'b1, portOutScl = 1'b1;
    logic dirDo = 1'b1, dirSda = 1'b0, dirScl = 1'b0;
    logic sdaPinIn, sclPinIn, doPinOut, doPinOe, doPullUp, sdaPinOut, sdaPinOe;
    logic sdaPullUp, sclPinOut, sclPinOe, sclPullUp, toggleClkPort;
    int err_count = 0;
    int checked = 0;

    serial_iface_wire_clock_select i_dut (
        .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .timerMatchA(timerMatchA), .timerMatch(timerMatch), .portOutDo(portOutDo),
        .portOutSda(portOutSda), .portOutScl(portOutScl), .dirDo(dirDo),
        .dirSda(dirSda), .dirScl(dirScl), .sdaPinIn(sdaPinIn), .sclPinIn(sclPinIn),
        .doPinOut(doPinOut), .doPinOe(doPinOe), .doPullUp(doPullUp),
        .sdaPinOut(sdaPinOut), .sdaPinOe(sdaPinOe), .sdaPullUp(sdaPullUp),
        .sclPinOut(sclPinOut), .sclPinOe(sclPinOe), .sclPullUp(sclPullUp),
        .toggleClkPort(toggleClkPort)
    );

    serial_far_end i_far (
        .clock(clock), .sdaPinOe(sdaPinOe), .sdaPinOut(sdaPinOut),
        .sclPinOe(sclPinOe), .sclPinOut(sclPinOut), .sdaPinIn(sdaPinIn),
        .sclPinIn(sclPinIn)
    );

    // Free-running 10 MHz system clock.
    always #50 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the read strobe.
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 check(regRdData, exp);
    endtask : rd

    // Pins are registered, so give them two edges before looking.
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    task automatic tick(input logic a, input logic m);
        @(posedge clock);
        timerMatchA <= a;
        timerMatch <= m;
        @(posedge clock);
        timerMatchA <= 1'b0;
        timerMatch <= 1'b0;
    endtask : tick

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////
    // Main sequence; the far end idles with both lines released.
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'hdb);
        rd(2'h0, 8'hd8);
        $display("Test control readback done");
        wr(2'h2, 8'ha5);
        wr(2'h1, 8'he0);
        wr(2'h0, 8'h10);
        settle();
        check(doPinOut, 1'b1);
        wr(2'h0, 8'h12);
        settle();
        check({doPinOut, doPinOe}, 2'h1);
        rd(2'h2, 8'h4b);
        // With the pin an input, its port bit alone decides the pull-up.
        @(posedge clock);
        dirDo <= 1'b0;
        settle();
        check({doPinOe, doPullUp}, 2'h1);
        wr(2'h0, 8'h10);
        rd(2'h1, 8'h01);
        for (int i = 0; i < 15; i++) begin
            wr(2'h0, 8'h12);
        end
        rd(2'h1, 8'h40);
        rd(2'h3, 8'hff);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h40);
        wr(2'h1, 8'h40);
        rd(2'h1, 8'h00);
        $display("Test soft strobe done");
        wr(2'h0, 8'h14);
        wr(2'h2, 8'h81);
        tick(1'b1, 1'b1);
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b1);
        tick(1'b0, 1'b1);
        wr(2'h0, 8'h16);
        rd(2'h2, 8'h07);
        rd(2'h1, 8'h03);
        $display("Test timer clock done");
        wr(2'h0, 8'h08);
        wr(2'h2, 8'h00);
        wr(2'h1, 8'h00);
        repeat (2) i_far.clk_pulse();
        rd(2'h2, 8'h03);
        rd(2'h1, 8'h04);
        wr(2'h0, 8'h0c);
        i_far.clk_pulse();
        rd(2'h2, 8'h07);
        rd(2'h1, 8'h06);
        wr(2'h0, 8'h0a);
        i_far.clk_pulse();
        rd(2'h2, 8'h0f);
        rd(2'h1, 8'h06);
        wr(2'h0, 8'h0b);
        #1 check(toggleClkPort, 1'b1);
        @(posedge clock);
        #1 check(toggleClkPort, 1'b0);
        rd(2'h1, 8'h07);
        $display("Test external clock done");
        wr(2'h2, 8'h00);
        wr(2'h0, 8'h20);
        wr(2'h1, 8'he0);
        @(posedge clock);
        dirScl <= 1'b1;
        settle();
        check(sclPinOe, 1'b0);
        i_far.set_sda(1'b1);
        settle();
        check(sclPinOe, 1'b1);
        rd(2'h1, 8'h80);
        i_far.set_sda(1'b0);
        wr(2'h1, 8'h80);
        settle();
        check(sclPinOe, 1'b0);
        wr(2'h1, 8'h0f);
        wr(2'h0, 8'h22);
        settle();
        check(sclPinOe, 1'b0);
        wr(2'h1, 8'h4f);
        wr(2'h0, 8'h32);
        settle();
        check(sclPinOe, 1'b1);
        wr(2'h1, 8'h40);
        settle();
        check(sclPinOe, 1'b0);
        @(posedge clock);
        portOutScl <= 1'b0;
        settle();
        check(sclPinOe, 1'b1);
        @(posedge clock);
        portOutScl <= 1'b1;
        wr(2'h0, 8'h20);
        @(posedge clock);
        dirSda <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(2'h2, i == 1 ? 8'h00 : 8'h80);
            @(posedge clock);
            portOutSda <= (i != 2);
            settle();
            check(sdaPinOe, i != 0);
        end
        wr(2'h0, 8'h00);
        settle();
        check({sdaPinOe, sdaPinOut, sdaPullUp}, 3'h4);
        @(posedge clock);
        dirSda <= 1'b0;
        portOutSda <= 1'b1;
        settle();
        check({sdaPinOe, sdaPinOut, sdaPullUp}, 3'h3);
        $display("Test two-wire done");
        test_done();
    end

    // Hang guard: the sequence needs well under a thousand cycles.
    initial begin
        #(5000 * 100);
        err_count++;
        test_done();
    end
endmodule : testbench

`default_nettype wire
